// File: src/dpr_pkg.sv
package dpr_pkg;

	localparam int ADDR_W = 18;
	localparam int ADDR_W_MID = 17;
	localparam int ADDR_W_SMALL = 16;
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DEPTH = 1 << ADDR_W;

	localparam logic [ADDR_W-1:0] MBOX_ADDR = 18'h3ffff;
	localparam logic [ADDR_W-1:0] MASK_RST = 18'h3ffff;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;

	// register byte offsets on the bus
	localparam logic [7:0] REG_MASK = 8'h00;
	localparam logic [7:0] REG_COUNTER = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_MEM_ADDR = 8'h0c;
	localparam logic [7:0] REG_MEM_HI = 8'h10;
	localparam logic [7:0] REG_MEM_DATA = 8'h14;

	// status field positions
	localparam int ST_MBOX = 0;
	localparam int ST_WRAP = 1;
	localparam int ST_NOP = 2;

	localparam int HI_W = DATA_W - 32;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

endpackage : dpr_pkg

// File: src/dpr_mem.sv
`timescale 1ns/10ps
// two-port storage; both read data words come out of registers
module dpr_mem (
	input wire logic sys_clk,
	input wire logic [dpr_pkg::ADDR_W-1:0] a_addr,
	input wire logic a_we,
	input wire logic [dpr_pkg::LANES-1:0] a_lanes,
	input wire logic [dpr_pkg::DATA_W-1:0] a_wdata,
	output logic [dpr_pkg::DATA_W-1:0] a_rdata,
	input wire logic [dpr_pkg::ADDR_W-1:0] b_addr,
	input wire logic b_we,
	input wire logic [dpr_pkg::DATA_W-1:0] b_wdata,
	output logic [dpr_pkg::DATA_W-1:0] b_rdata
);
	logic [dpr_pkg::DATA_W-1:0] mem [dpr_pkg::DEPTH];

	// read-first on both ports; a colliding read sees the old word
	always_ff @(posedge sys_clk) begin
		a_rdata <= mem[a_addr];
		b_rdata <= mem[b_addr];
		if (b_we) begin
			mem[b_addr] <= b_wdata;
		end
		for (int i = 0; i < dpr_pkg::LANES; i++) begin
			if (a_we && a_lanes[i]) begin
				mem[a_addr][i*dpr_pkg::LANE_W +: dpr_pkg::LANE_W] <=
					a_wdata[i*dpr_pkg::LANE_W +: dpr_pkg::LANE_W];
			end
		end
	end

endmodule : dpr_mem

// File: src/dpr_port.sv
`timescale 1ns/10ps
// one synchronous port of the dual-port ram, bus side acting as the far port
module dpr_port (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic master_clear_n,
	input wire logic select_low_active,
	input wire logic select_high_active,
	input wire logic rd_wr_n,
	input wire logic output_enable_n,
	input wire logic [dpr_pkg::LANES-1:0] byte_lane_enables_n,
	input wire logic address_strobe_n,
	input wire logic counter_advance_n,
	input wire logic counter_or_mask_select,
	input wire logic counter_clear_n,
	input wire logic [dpr_pkg::ADDR_W-1:0] addr_lines_in,
	output logic [dpr_pkg::ADDR_W-1:0] addr_lines_out,
	output logic addr_lines_oe,
	input wire logic [dpr_pkg::DATA_W-1:0] data_lines_in,
	output logic [dpr_pkg::DATA_W-1:0] data_lines_out,
	output logic data_lines_oe,
	output logic counter_wrap_flag_n,
	output logic mailbox_flag_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	localparam int AW = dpr_pkg::ADDR_W;
	localparam int DW = dpr_pkg::DATA_W;

	typedef struct packed {
		logic [AW-1:0] cnt;
		logic [AW-1:0] base;
		logic [AW-1:0] mask;
		logic [AW-1:0] acc_addr;
		logic [DW-1:0] wr_data;
		logic [dpr_pkg::LANES-1:0] wr_lanes;
		logic wr_pend;
		logic rd_pend;
		logic data_oe;
		logic rb_pend;
		logic rb_cnt;
		logic addr_oe;
		logic [AW-1:0] addr_out;
		logic wrap_n;
		logic mbox_n;
		logic nop_seen;
		logic ahb_wr;
		logic [7:0] ahb_addr;
		logic [AW-1:0] mem_addr;
		logic [dpr_pkg::HI_W-1:0] mem_hi;
		logic [31:0] hrdata;
		logic hreadyout;
	} dpr_state_type;

	dpr_state_type st_r;
	dpr_state_type st_nxt;

	logic port_rst_n;
	logic sel;
	logic wr_req;
	logic rd_req;
	logic nop;
	logic ahb_take;
	logic mbox_wr;
	logic [DW-1:0] b_rdata;
	logic [DW-1:0] a_rdata;

	// increments only the bits the mask leaves free
	function automatic logic [AW-1:0] masked_inc(input logic [AW-1:0] v, input logic [AW-1:0] m);
		logic [AW-1:0] s;
		s = AW'((v & m) + AW'(1));
		return (v & ~m) | (s & m);
	endfunction : masked_inc

	// true when the free bits are all ones
	function automatic logic at_max(input logic [AW-1:0] v, input logic [AW-1:0] m);
		return (v & m) == m;
	endfunction : at_max

	// master clear acts without the clock, like the system reset
	assign port_rst_n = rst_n & master_clear_n;

	// internal select and request decode
	assign sel = !select_low_active && select_high_active;
	assign wr_req = sel && !rd_wr_n;
	assign rd_req = sel && rd_wr_n;
	assign nop = wr_req && st_r.rd_pend && !output_enable_n;
	assign ahb_take = hsel && hready && (htrans == dpr_pkg::HTRANS_NONSEQ || htrans[1]);
	assign mbox_wr = st_r.ahb_wr && st_r.ahb_addr == dpr_pkg::REG_MEM_DATA
		&& st_r.mem_addr == dpr_pkg::MBOX_ADDR;

	// next-state logic for the pin port and the bus slave
	always_comb begin
		logic [AW-1:0] acc;
		acc = st_r.cnt;
		st_nxt = st_r;
		st_nxt.wr_pend = 1'b0;
		st_nxt.rd_pend = 1'b0;
		st_nxt.rb_pend = 1'b0;
		st_nxt.wrap_n = 1'b1;
		st_nxt.ahb_wr = 1'b0;
		st_nxt.hreadyout = 1'b1;

		// burst counter
		if (!counter_clear_n) begin
			st_nxt.cnt = dpr_pkg::ADDR_ZERO;
			st_nxt.base = dpr_pkg::ADDR_ZERO;
		end else if (!address_strobe_n && !counter_advance_n) begin
			if (counter_or_mask_select) begin
				st_nxt.cnt = addr_lines_in;
				st_nxt.base = addr_lines_in;
			end else begin
				st_nxt.mask = addr_lines_in;
			end
		end else if (address_strobe_n && !counter_advance_n) begin
			if (at_max(st_r.cnt, st_r.mask)) begin
				st_nxt.cnt = st_r.base;
			end else begin
				st_nxt.cnt = masked_inc(st_r.cnt, st_r.mask);
				st_nxt.wrap_n = !at_max(st_nxt.cnt, st_r.mask);
			end
		end else if (!address_strobe_n && counter_advance_n) begin
			st_nxt.rb_pend = 1'b1;
			st_nxt.rb_cnt = counter_or_mask_select;
		end
		acc = st_nxt.cnt;

		// readback drives the address lines one cycle later, for one cycle
		st_nxt.addr_oe = st_r.rb_pend;
		if (st_r.rb_pend) begin
			st_nxt.addr_out = st_r.rb_cnt ? st_r.cnt : st_r.mask;
		end

		// accesses take the address that this edge settles on
		if (wr_req && !nop) begin
			st_nxt.wr_pend = 1'b1;
			st_nxt.acc_addr = acc;
			st_nxt.wr_data = data_lines_in;
			st_nxt.wr_lanes = ~byte_lane_enables_n;
		end else if (rd_req) begin
			st_nxt.rd_pend = 1'b1;
			st_nxt.acc_addr = acc;
		end
		if (nop) begin
			st_nxt.nop_seen = 1'b1;
		end
		// read data drives for one cycle behind the read edge
		st_nxt.data_oe = st_r.rd_pend;

		// mailbox: far-side write sets, own read of the location clears
		if (rd_req && acc == dpr_pkg::MBOX_ADDR && byte_lane_enables_n != '1) begin
			st_nxt.mbox_n = 1'b1;
		end
		if (mbox_wr) begin
			st_nxt.mbox_n = 1'b0;
		end

		// bus writes land in the data phase
		if (st_r.ahb_wr) begin
			unique case (st_r.ahb_addr)
				dpr_pkg::REG_MASK: st_nxt.mask = hwdata[AW-1:0];
				dpr_pkg::REG_STATUS: begin
					if (hwdata[dpr_pkg::ST_NOP] && !nop) begin
						st_nxt.nop_seen = 1'b0;
					end
				end
				dpr_pkg::REG_MEM_ADDR: st_nxt.mem_addr = hwdata[AW-1:0];
				dpr_pkg::REG_MEM_HI: st_nxt.mem_hi = hwdata[dpr_pkg::HI_W-1:0];
				default: ;
			endcase
		end

		// address phase: take writes, answer reads from current state
		if (ahb_take) begin
			st_nxt.ahb_wr = hwrite;
			st_nxt.ahb_addr = haddr[7:0];
			st_nxt.hrdata = 32'h0;
			if (!hwrite) begin
				unique case (haddr[7:0])
					dpr_pkg::REG_MASK: st_nxt.hrdata = 32'(st_r.mask);
					dpr_pkg::REG_COUNTER: st_nxt.hrdata = 32'(st_r.cnt);
					dpr_pkg::REG_STATUS: begin
						st_nxt.hrdata[dpr_pkg::ST_MBOX] = !st_r.mbox_n;
						st_nxt.hrdata[dpr_pkg::ST_WRAP] = !st_r.wrap_n;
						st_nxt.hrdata[dpr_pkg::ST_NOP] = st_r.nop_seen;
					end
					dpr_pkg::REG_MEM_ADDR: st_nxt.hrdata = 32'(st_r.mem_addr);
					dpr_pkg::REG_MEM_HI: st_nxt.hrdata = 32'(b_rdata[DW-1:32]);
					dpr_pkg::REG_MEM_DATA: st_nxt.hrdata = b_rdata[31:0];
					default: st_nxt.hrdata = 32'h0;
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge port_rst_n) begin
		if (!port_rst_n) begin
			st_r <= '0;
			st_r.mask <= dpr_pkg::MASK_RST;
			st_r.wrap_n <= 1'b1;
			st_r.mbox_n <= 1'b1;
			st_r.hreadyout <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// storage: pin port on side a, bus on side b
	dpr_mem u_mem (
		.sys_clk(sys_clk),
		.a_addr(st_r.acc_addr),
		.a_we(st_r.wr_pend),
		.a_lanes(st_r.wr_lanes),
		.a_wdata(st_r.wr_data),
		.a_rdata(a_rdata),
		.b_addr(st_r.mem_addr),
		.b_we(st_r.ahb_wr && st_r.ahb_addr == dpr_pkg::REG_MEM_DATA),
		.b_wdata({st_r.mem_hi, hwdata}),
		.b_rdata(b_rdata)
	);

	// outputs
	assign data_lines_out = a_rdata;
	assign data_lines_oe = st_r.data_oe && !output_enable_n;
	assign addr_lines_out = st_r.addr_out;
	assign addr_lines_oe = st_r.addr_oe;
	assign counter_wrap_flag_n = st_r.wrap_n;
	assign mailbox_flag_n = st_r.mbox_n;
	assign hreadyout = st_r.hreadyout;
	assign hresp = dpr_pkg::HRESP_OKAY;
	assign hrdata = st_r.hrdata;

	AST_READ_PIPE: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		rd_req |-> ##1 st_r.rd_pend ##1 st_r.data_oe)
		else $error("read not driven on second edge");

	AST_DESELECT: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		!sel |-> ##2 !st_r.data_oe)
		else $error("data still driven after deselect");

	AST_OE_ASYNC: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		output_enable_n |-> !data_lines_oe)
		else $error("data driven with output enable high");

	AST_LOAD: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		(counter_clear_n && !address_strobe_n && !counter_advance_n && counter_or_mask_select)
		|=> st_r.cnt == $past(addr_lines_in))
		else $error("address not loaded");

	AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		(!counter_clear_n && wr_req && !nop) |=> st_r.cnt == '0 && st_r.wr_pend)
		else $error("clear blocked the access or left counter");

	AST_WRAP_FLAG: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		!counter_wrap_flag_n |-> at_max(st_r.cnt, st_r.mask)
		&& $past(address_strobe_n) && !$past(counter_advance_n))
		else $error("wrap flag without reaching maximum");

	AST_RETRANSMIT: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		(counter_clear_n && address_strobe_n && !counter_advance_n && at_max(st_r.cnt, st_r.mask))
		|=> st_r.cnt == $past(st_r.base))
		else $error("counter did not resume from base");

	AST_READBACK: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		(counter_clear_n && !address_strobe_n && counter_advance_n && counter_or_mask_select)
		|-> ##2 addr_lines_oe && addr_lines_out == $past(st_r.cnt, 1))
		else $error("counter readback missing");

	AST_NOP: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		nop |=> !st_r.wr_pend ##1 !st_r.data_oe)
		else $error("turnaround cycle wrote or drove");

	AST_MBOX: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		mbox_wr |=> !mailbox_flag_n)
		else $error("mailbox write did not raise flag");

	AST_LANES: assert property (@(posedge sys_clk) disable iff (!port_rst_n)
		(wr_req && !nop) |=> st_r.wr_lanes == ~$past(byte_lane_enables_n))
		else $error("byte lanes not captured");

endmodule : dpr_port

// File: sim/dpr_host.sv
`timescale 1ns/10ps
// behavioural host controller on the pin side of one port
module dpr_host (
	input wire logic sys_clk,
	input wire logic [dpr_pkg::ADDR_W-1:0] addr_lines_out,
	input wire logic addr_lines_oe,
	output logic select_low_active,
	output logic select_high_active,
	output logic rd_wr_n,
	output logic output_enable_n,
	output logic [dpr_pkg::LANES-1:0] byte_lane_enables_n,
	output logic address_strobe_n,
	output logic counter_advance_n,
	output logic counter_or_mask_select,
	output logic counter_clear_n,
	output logic [dpr_pkg::ADDR_W-1:0] addr_lines_in,
	output logic [dpr_pkg::DATA_W-1:0] data_lines_in
);
	logic [dpr_pkg::ADDR_W-1:0] adr_q;
	logic [dpr_pkg::ADDR_W-1:0] adr_last;
	logic [dpr_pkg::DATA_W-1:0] dat_q;

	// address driven only for loads so readback finds the bus free; a free bus inverts
	assign addr_lines_in = addr_lines_oe ? addr_lines_out :
		(!address_strobe_n && !counter_advance_n) ? adr_q : ~adr_last;
	// data driven only while writing
	assign data_lines_in = !rd_wr_n ? dat_q : ~dat_q;

	always @(posedge sys_clk) adr_last <= addr_lines_in;

	// idle, deselected, holding the counter
	initial begin
		{select_low_active, select_high_active, rd_wr_n, address_strobe_n} = 4'hb;
		{counter_advance_n, counter_or_mask_select, counter_clear_n} = 3'h7;
		output_enable_n = 1'b0;
		byte_lane_enables_n = 4'h0;
		adr_q = '0;
		adr_last = '0;
		dat_q = '0;
	end

	// one cycle: c = {sel_lo, sel_hi, rd, strobe_n, advance_n, cnt_sel, clear_n}
	task drive(input logic [6:0] c, input logic [dpr_pkg::ADDR_W-1:0] a,
		input logic [dpr_pkg::DATA_W-1:0] d, input logic [dpr_pkg::LANES-1:0] ln);
		@(posedge sys_clk);
		{select_low_active, select_high_active, rd_wr_n} <= c[6:4];
		{address_strobe_n, counter_advance_n, counter_or_mask_select} <= c[3:1];
		counter_clear_n <= c[0];
		adr_q <= a;
		dat_q <= d;
		byte_lane_enables_n <= ln;
	endtask : drive
endmodule : dpr_host

// File: sim/sync_dual_port_ram_port_tb_top.sv
`timescale 1ns/10ps
// self-checking bench: pins through the host model, registers over ahb-lite
module sync_dual_port_ram_port_tb_top;
	localparam logic [6:0] C_IDLE = 7'h7f;
	localparam logic [6:0] C_RD = 7'h33;
	localparam logic [6:0] C_WR = 7'h23;
	localparam logic [6:0] C_HALF = 7'h13;
	localparam logic [6:0] C_LD = 7'h73;
	localparam logic [6:0] C_INC = 7'h7b;
	localparam logic [6:0] C_MSK = 7'h71;
	localparam logic [6:0] C_RBC = 7'h77;
	localparam logic [6:0] C_RBM = 7'h75;
	localparam logic [6:0] C_CLR = 7'h3e;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hrdata;
	logic [31:0] rd_q;
	logic hreadyout, hresp, addr_lines_oe, data_lines_oe, counter_wrap_flag_n, mailbox_flag_n;
	logic select_low_active, select_high_active, rd_wr_n, output_enable_n;
	logic address_strobe_n, counter_advance_n, counter_or_mask_select, counter_clear_n;
	logic [dpr_pkg::LANES-1:0] byte_lane_enables_n;
	logic [dpr_pkg::ADDR_W-1:0] addr_lines_in, addr_lines_out;
	logic [dpr_pkg::DATA_W-1:0] data_lines_in, data_lines_out;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int n_wrap = 0;
	int w0;

	dpr_port i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .master_clear_n(1'b1),
		.select_low_active(select_low_active), .select_high_active(select_high_active),
		.rd_wr_n(rd_wr_n), .output_enable_n(output_enable_n),
		.byte_lane_enables_n(byte_lane_enables_n), .address_strobe_n(address_strobe_n),
		.counter_advance_n(counter_advance_n), .counter_or_mask_select(counter_or_mask_select),
		.counter_clear_n(counter_clear_n), .addr_lines_in(addr_lines_in),
		.addr_lines_out(addr_lines_out), .addr_lines_oe(addr_lines_oe),
		.data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
		.data_lines_oe(data_lines_oe), .counter_wrap_flag_n(counter_wrap_flag_n),
		.mailbox_flag_n(mailbox_flag_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

	dpr_host i_host (.sys_clk(sys_clk), .addr_lines_out(addr_lines_out),
		.addr_lines_oe(addr_lines_oe), .select_low_active(select_low_active),
		.select_high_active(select_high_active), .rd_wr_n(rd_wr_n),
		.output_enable_n(output_enable_n), .byte_lane_enables_n(byte_lane_enables_n),
		.address_strobe_n(address_strobe_n), .counter_advance_n(counter_advance_n),
		.counter_or_mask_select(counter_or_mask_select), .counter_clear_n(counter_clear_n),
		.addr_lines_in(addr_lines_in), .data_lines_in(data_lines_in));

	always #25 sys_clk = ~sys_clk;

	// cycle count for the hang limit, and wrap pulse count
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (counter_wrap_flag_n === 1'b0) n_wrap <= n_wrap + 1;
		if (cycles == 3000) begin
			n_errors++;
			close_out();
		end
	end

	task close_out;
		if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// single ahb-lite transfer; read data is the value standing at the data-phase edge
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		htrans <= dpr_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd_q = hrdata;
	endtask : ahb

	task rd(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk("hrdata", {4'h0, exp}, {4'h0, rd_q});
	endtask : rd

	task pin_wr(input logic [17:0] a, input logic [35:0] d, input logic [3:0] ln);
		i_host.drive(C_WR, a, d, ln);
		i_host.drive(C_IDLE, a, d, 4'hf);
	endtask : pin_wr

	// request, idle, then stop in the cycle where the answer stands
	task step2(input logic [6:0] c, input logic [17:0] a);
		i_host.drive(c, a, 36'h0, 4'h0);
		i_host.drive(C_IDLE, a, 36'h0, 4'h0);
		@(posedge sys_clk);
		@(negedge sys_clk);
	endtask : step2

	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(dpr_pkg::REG_MASK, 32'h3ffff);
		rd(dpr_pkg::REG_COUNTER, 32'h0);
		chk("hresp", {35'h0, dpr_pkg::HRESP_OKAY}, {35'h0, hresp});
		chk("hreadyout", 36'h1, {35'h0, hreadyout});
		ahb(1'b1, 8'h40, 32'hffffffff);
		rd(8'h40, 32'h0);
		// full word, then one lane over it
		pin_wr(18'h00012, 36'h987654321, 4'h0);
		pin_wr(18'h00012, 36'h012345678, 4'he);
		step2(C_RD, 18'h00012);
		chk("data_lines_out", 36'h987654278, data_lines_out);
		chk("data_lines_oe", 36'h1, {35'h0, data_lines_oe});
		i_host.output_enable_n = 1'b1;
		#1;
		chk("data_lines_oe", 36'h0, {35'h0, data_lines_oe});
		i_host.output_enable_n = 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk("data_lines_oe", 36'h0, {35'h0, data_lines_oe});
		step2(C_HALF, 18'h00012);
		chk("data_lines_oe", 36'h0, {35'h0, data_lines_oe});
		// write straight after a read with output enable low is dropped
		i_host.drive(C_RD, 18'h00012, 36'h0, 4'h0);
		i_host.drive(C_WR, 18'h00012, 36'h0aaaaaaaa, 4'h0);
		i_host.drive(C_IDLE, 18'h00012, 36'h0, 4'hf);
		ahb(1'b0, dpr_pkg::REG_STATUS, 32'h0);
		chk("nop seen", 36'h1, {35'h0, rd_q[dpr_pkg::ST_NOP]});
		step2(C_RD, 18'h00012);
		chk("data_lines_out", 36'h987654278, data_lines_out);
		pin_wr(18'h00012, 36'h0aaaaaaaa, 4'h0);
		step2(C_RD, 18'h00012);
		chk("data_lines_out", 36'h0aaaaaaaa, data_lines_out);
		// far port writes, pin reads, and back
		ahb(1'b1, dpr_pkg::REG_MEM_ADDR, 32'h155);
		ahb(1'b1, dpr_pkg::REG_MEM_HI, 32'h5);
		ahb(1'b1, dpr_pkg::REG_MEM_DATA, 32'h13572468);
		step2(C_RD, 18'h00155);
		chk("data_lines_out", 36'h513572468, data_lines_out);
		pin_wr(18'h00155, 36'hc0f0f0f0f, 4'h0);
		// let the pin write land before the far port looks
		@(posedge sys_clk);
		rd(dpr_pkg::REG_MEM_DATA, 32'h0f0f0f0f);
		rd(dpr_pkg::REG_MEM_HI, 32'hc);
		// burst counter with a two-bit mask
		w0 = n_wrap;
		i_host.drive(C_MSK, 18'h00003, 36'h0, 4'h0);
		i_host.drive(C_LD, 18'h00010, 36'h0, 4'h0);
		repeat (2) i_host.drive(C_INC, 18'h0, 36'h0, 4'h0);
		step2(C_RBC, 18'h0);
		chk("addr_lines_oe", 36'h1, {35'h0, addr_lines_oe});
		chk("counter", 36'h12, {18'h0, addr_lines_out});
		repeat (2) i_host.drive(C_INC, 18'h0, 36'h0, 4'h0);
		step2(C_RBC, 18'h0);
		chk("counter", 36'h10, {18'h0, addr_lines_out});
		chk("wrap pulses", 36'h1, 36'(n_wrap - w0));
		step2(C_RBM, 18'h0);
		chk("mask", 36'h3, {18'h0, addr_lines_out});
		// clear with a read in the same cycle
		pin_wr(18'h00000, 36'h0deadbeef, 4'h0);
		i_host.drive(C_LD, 18'h00155, 36'h0, 4'h0);
		step2(C_CLR, 18'h0);
		chk("data_lines_out", 36'h0deadbeef, data_lines_out);
		step2(C_RBC, 18'h0);
		chk("counter", 36'h0, {18'h0, addr_lines_out});
		// mailbox set from the far port, cleared by a pin read
		ahb(1'b1, dpr_pkg::REG_MEM_ADDR, 32'h3ffff);
		ahb(1'b1, dpr_pkg::REG_MEM_DATA, 32'h1);
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk("mailbox_flag_n", 36'h0, {35'h0, mailbox_flag_n});
		step2(C_RD, 18'h3ffff);
		chk("mailbox_flag_n", 36'h1, {35'h0, mailbox_flag_n});
		close_out();
	end
endmodule : sync_dual_port_ram_port_tb_top
